// ==== hw/fpsb_top.sv ====
`timescale 1ns/100ps
module fpsb_top #(
  parameter int CFG_CYC   = fpsb_pkg::CFG_CYC,
  parameter int DTACK_CYC = fpsb_pkg::DTACK_CYC,
  parameter int MEB_DEPTH = fpsb_pkg::MEB_DEPTH
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  gate_i,
  input  wire logic                  veto_i,
  input  wire logic                  fast_clear_input_i,
  input  wire logic                  ext_reset_i,
  input  wire logic                  busy_bus_i,
  input  wire logic                  busy_scope_jumper_i,
  input  wire logic                  overcurrent_i,
  input  wire logic [13:0]           term_sw_i,
  input  wire logic [15:0]           rot_sw_i,
  output logic                       busy_o,
  output logic                       data_ready_o,
  output logic                       acq_halt_o,
  output logic                       conv_start_o,
  output logic      [15:0]           base_addr_o,
  output logic      [11:0]           thr_counts_o,
  output logic      [11:0]           max_count_o,
  output fpsb_pkg::fpsb_led_t        led_o
);
  localparam int CVW = $clog2(fpsb_pkg::CONV_CYC + 1);
  localparam int CLW = $clog2(fpsb_pkg::FAST_CLEAR_INPUT_CYC + 1);
  localparam int CGW = $clog2(CFG_CYC + 1);
  localparam int MW  = $clog2(MEB_DEPTH + 1);
  if (CFG_CYC < 1 || DTACK_CYC < 1 || MEB_DEPTH < 1)
  begin : g_bad_param
    $error("counts and depth must be at least one");
  end
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 7 + fpsb_pkg::N_TERM + $bits(rot_sw_i);
  logic [NS-1:0] pin_s;
  logic gate_s, veto_s, fast_clear_input_s, xrst_s, bbus_s, jmp_s, ovc_s;
  logic [13:0] term_s;
  logic [15:0] rot_s;
  fpsb_sync #(.W(NS)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({gate_i, veto_i, fast_clear_input_i, ext_reset_i, busy_bus_i,
             busy_scope_jumper_i, overcurrent_i, term_sw_i,
             rot_sw_i}),
    .q_o   (pin_s)
  );
  assign {gate_s, veto_s, fast_clear_input_s, xrst_s, bbus_s, jmp_s, ovc_s, term_s,
          rot_s} = pin_s;
  logic gate_d, fast_clear_input_d, xrst_d;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_d <= 1'b0;
      fast_clear_input_d <= 1'b0;
      xrst_d <= 1'b0;
    end
    else
    begin
      gate_d <= gate_s;
      fast_clear_input_d <= fast_clear_input_s;
      xrst_d <= xrst_s;
    end
  end
  logic gate_rise, fast_clear_input_rise, xrst_rise;
  assign gate_rise = gate_s & ~gate_d;
  assign fast_clear_input_rise = fast_clear_input_s & ~fast_clear_input_d;
  assign xrst_rise = xrst_s & ~xrst_d;
  // ----------------------------------------------------------------
  // power-on configuration phase
  // ----------------------------------------------------------------
  logic [CGW-1:0] cfg_reg;
  logic           cfg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_reg <= CGW'(CFG_CYC);
    else if (cfg_reg != '0)
      cfg_reg <= cfg_reg - 1'b1;
  end
  assign cfg = (cfg_reg != '0);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic        wr_take;
  logic [3:0]  ctrl_reg;
  logic [7:0]  thr_reg;
  logic [15:0] base_reg;
  logic [MW-1:0] meb_reg;
  logic        own_busy;
  logic        meb_full;
  logic        pop;
  assign wb_ack_o = ack_reg;
  // a write lands on the edge where the master sees ack
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (wb_cyc_i & wb_stb_i & ~ack_reg)
    begin
      wb_dat_o <= '0;
      if (wb_adr_i == fpsb_pkg::ADR_STATUS)
      begin
        wb_dat_o[fpsb_pkg::ST_DATA_PRESENT_INDICATOR] <= data_ready_o;
        wb_dat_o[fpsb_pkg::ST_CFG]  <= cfg;
        wb_dat_o[fpsb_pkg::ST_BUSY] <= own_busy;
        wb_dat_o[fpsb_pkg::ST_BBUS] <= bbus_s;
      end
      else if (wb_adr_i == fpsb_pkg::ADR_CTRL)
        wb_dat_o[3:0] <= ctrl_reg;
      else if (wb_adr_i == fpsb_pkg::ADR_THR)
        wb_dat_o[7:0] <= thr_reg;
      else if (wb_adr_i == fpsb_pkg::ADR_BASE)
        wb_dat_o[15:0] <= base_reg;
      else if (wb_adr_i == fpsb_pkg::ADR_EVENT)
        wb_dat_o[MW-1:0] <= meb_reg;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || xrst_rise)
    begin
      ctrl_reg <= fpsb_pkg::CTRL_RST;
      thr_reg  <= fpsb_pkg::THR_RST;
      base_reg <= fpsb_pkg::BASE_RST;
    end
    else if (wr_take)
    begin
      if (wb_adr_i == fpsb_pkg::ADR_CTRL && wb_sel_i[0])
        ctrl_reg <= wb_dat_i[3:0];
      else if (wb_adr_i == fpsb_pkg::ADR_THR && wb_sel_i[0])
        thr_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == fpsb_pkg::ADR_BASE)
      begin
        if (wb_sel_i[0])
          base_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          base_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  assign pop = wr_take & (wb_adr_i == fpsb_pkg::ADR_EVENT) & wb_sel_i[0];
  // ----------------------------------------------------------------
  // acquisition control
  // ----------------------------------------------------------------
  fpsb_pkg::fpsb_state_t st_reg;
  logic [CVW-1:0] conv_reg;
  logic [CLW-1:0] clr_reg;
  logic           conv_done;
  assign meb_full = (meb_reg == MW'(MEB_DEPTH));
  assign own_busy = (st_reg != fpsb_pkg::ST_IDLE) | (clr_reg != '0)
                  | ctrl_reg[fpsb_pkg::CT_MTEST] | meb_full;
  assign acq_halt_o = jmp_s ? (own_busy | bbus_s) : own_busy;
  assign conv_start_o = gate_rise & ~veto_s & ~acq_halt_o
                      & ~cfg & ~fast_clear_input_rise & ~xrst_rise;
  assign conv_done = (st_reg == fpsb_pkg::ST_CONV) & (conv_reg == CVW'(1))
                   & ~fast_clear_input_rise & ~xrst_rise;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg   <= fpsb_pkg::ST_IDLE;
      conv_reg <= '0;
    end
    else if (xrst_rise)
    begin
      st_reg   <= fpsb_pkg::ST_ARST;
      conv_reg <= CVW'(fpsb_pkg::FAST_CLEAR_INPUT_CYC);
    end
    else if (fast_clear_input_rise)
    begin
      st_reg   <= fpsb_pkg::ST_IDLE;
      conv_reg <= '0;
    end
    else
    begin
      case (st_reg)
        fpsb_pkg::ST_IDLE:
          if (conv_start_o)
          begin
            st_reg   <= fpsb_pkg::ST_CONV;
            conv_reg <= CVW'(fpsb_pkg::CONV_CYC);
          end
        fpsb_pkg::ST_CONV, fpsb_pkg::ST_ARST:
        begin
          conv_reg <= conv_reg - 1'b1;
          if (conv_reg == CVW'(1))
            st_reg <= fpsb_pkg::ST_IDLE;
        end
        default:
          st_reg <= fpsb_pkg::ST_IDLE;
      endcase
    end
  end
  // the analog clear holds off new gates for the full window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clr_reg <= '0;
    else if (fast_clear_input_rise)
      clr_reg <= CLW'(fpsb_pkg::FAST_CLEAR_INPUT_CYC);
    else if (clr_reg != '0)
      clr_reg <= clr_reg - 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || xrst_rise)
      meb_reg <= '0;
    else if (conv_done && !(pop && meb_reg != '0))
      meb_reg <= meb_reg + 1'b1;
    else if (!conv_done && pop && meb_reg != '0)
      meb_reg <= meb_reg - 1'b1;
  end
  // ----------------------------------------------------------------
  // settings driven out to the converter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_addr_o  <= '0;
      thr_counts_o <= '0;
      max_count_o  <= fpsb_pkg::FSR_FULL;
    end
    else
    begin
      base_addr_o <= ctrl_reg[fpsb_pkg::CT_AREG] ? base_reg : rot_s;
      thr_counts_o <= ctrl_reg[fpsb_pkg::CT_FINE]
        ? 12'({thr_reg, 1'b0}) : {thr_reg, 4'h0};
      max_count_o <= ctrl_reg[fpsb_pkg::CT_SLIDE]
        ? fpsb_pkg::FSR_SLIDE : fpsb_pkg::FSR_FULL;
    end
  end
  // ----------------------------------------------------------------
  // status outputs and indicators
  // ----------------------------------------------------------------
  logic dtack_led;
  logic ovc_reg;
  fpsb_stretch #(.CYC(DTACK_CYC)) u_dtack (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pulse_i (ack_reg),
    .led_o   (dtack_led)
  );
  // only a power cycle, seen here as rst_i, clears the over-current latch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovc_reg <= 1'b0;
    else if (ovc_s)
      ovc_reg <= 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o       <= 1'b0;
      data_ready_o <= 1'b0;
      led_o        <= '0;
    end
    else
    begin
      busy_o            <= own_busy;
      data_ready_o      <= (meb_reg != '0);
      led_o.dtack       <= dtack_led;
      led_o.busy        <= own_busy | cfg;
      led_o.data_present_indicator        <= (meb_reg != '0) | cfg;
      led_o.term_green  <= ~cfg & (&term_s);
      led_o.term_red    <= ~cfg & ~(|term_s);
      led_o.term_orange <= cfg;
      led_o.pwr_green   <= ~ovc_reg & ~ovc_s;
      led_o.pwr_orange  <= ovc_reg | ovc_s;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  dtack_lit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_reg |-> ##2 led_o.dtack)
    else $error("ack not shown on indicator");
  conv_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start_o |=> (st_reg == fpsb_pkg::ST_CONV) && own_busy
      && conv_reg == CVW'(fpsb_pkg::CONV_CYC))
    else $error("conversion interval not loaded");
  cfg_leds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg |=> led_o.busy && led_o.data_present_indicator && led_o.term_orange
      && !led_o.term_green)
    else $error("configuration display wrong");
  term_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg && (&term_s)) |=> led_o.term_green && !led_o.term_red)
    else $error("termination green missing");
  halt_scope_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (jmp_s && bbus_s) |-> acq_halt_o && !conv_start_o)
    else $error("bus busy did not halt");
  own_scope_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!jmp_s && !own_busy) |-> !acq_halt_o)
    else $error("foreign busy halted board");
  veto_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    veto_s |-> !conv_start_o)
    else $error("conversion started under veto");
  fast_clear_input_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_clear_input_rise |=> (!conv_start_o) [*8])
    else $error("gate accepted in clear window");
  fast_clear_input_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fast_clear_input_rise && !xrst_rise) |=> st_reg == fpsb_pkg::ST_IDLE
      && meb_reg == $past(meb_reg) - MW'($past(pop) && $past(meb_reg) != '0))
    else $error("fast clear stored an event");
  data_present_indicator_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_reg && wb_adr_i == fpsb_pkg::ADR_STATUS)
      |=> wb_dat_o[fpsb_pkg::ST_DATA_PRESENT_INDICATOR] == $past(data_ready_o)
      && wb_dat_o[fpsb_pkg::ST_BUSY] == $past(own_busy))
    else $error("status bits do not mirror state");
  ovc_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    led_o.pwr_orange |=> led_o.pwr_orange && !led_o.pwr_green)
    else $error("over-current indication released");
endmodule

// ==== hw/fpsb_pkg.sv ====
package fpsb_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 125;
  localparam int CONV_NS   = 5700;
  localparam int CONV_CYC  = CONV_NS * CLK_MHZ / 1000;
  localparam int FAST_CLEAR_INPUT_NS   = 600;
  localparam int FAST_CLEAR_INPUT_CYC  = (FAST_CLEAR_INPUT_NS * CLK_MHZ + 999) / 1000;
  localparam int CFG_US    = 1000;
  localparam int CFG_CYC   = CFG_US * CLK_MHZ;
  localparam int DTACK_MS  = 50;
  localparam int DTACK_CYC = DTACK_MS * CLK_MHZ * 1000;
  // ----------------------------------------------------------------
  // data path figures
  // ----------------------------------------------------------------
  localparam int MEB_DEPTH       = 32;
  localparam int N_TERM          = 14;
  localparam int N_ROT           = 4;
  localparam logic [11:0] FSR_FULL  = 12'hFFF;
  localparam logic [11:0] FSR_SLIDE = 12'hF00;
  localparam int THR_COARSE_SH   = 4;
  localparam int THR_FINE_SH     = 1;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CTRL   = 8'h04;
  localparam logic [7:0] ADR_THR    = 8'h08;
  localparam logic [7:0] ADR_BASE   = 8'h0C;
  localparam logic [7:0] ADR_EVENT  = 8'h10;
  localparam int ST_DATA_PRESENT_INDICATOR = 0;
  localparam int ST_CFG  = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_BBUS = 3;
  localparam int CT_MTEST = 0;
  localparam int CT_SLIDE = 1;
  localparam int CT_FINE  = 2;
  localparam int CT_AREG  = 3;
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [7:0]  THR_RST  = 8'h00;
  localparam logic [15:0] BASE_RST = 16'h0000;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_ARST = 3'b100
  } fpsb_state_t;
  typedef struct packed {
    logic dtack;
    logic busy;
    logic data_present_indicator;
    logic term_green;
    logic term_red;
    logic term_orange;
    logic pwr_green;
    logic pwr_orange;
  } fpsb_led_t;
endpackage

// ==== hw/fpsb_sync.sv ====
`timescale 1ns/100ps
module fpsb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  if (W < 1)
  begin : g_bad_param
    $error("synchroniser width must be at least one");
  end
  logic [W-1:0] meta_reg;
  // ----------------------------------------------------------------
  // two-flop chain per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        meta_reg[i] <= 1'b0;
        q_o[i]      <= 1'b0;
      end
      else
      begin
        meta_reg[i] <= d_i[i];
        q_o[i]      <= meta_reg[i];
      end
    end
  end
endmodule

// ==== hw/fpsb_stretch.sv ====
`timescale 1ns/100ps
module fpsb_stretch #(
  parameter int CYC = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pulse_i,
  output logic      led_o
);
  localparam int CW = $clog2(CYC + 1);
  if (CYC < 1)
  begin : g_bad_param
    $error("stretch length must be at least one cycle");
  end
  logic [CW-1:0] cnt_reg;
  // ----------------------------------------------------------------
  // retrigger on each pulse so back-to-back accesses stay lit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else if (pulse_i)
      cnt_reg <= CW'(CYC);
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      led_o <= 1'b0;
    else
      led_o <= pulse_i | (cnt_reg > CW'(1));
  end
endmodule

// ==== tb/fpsb_cbus_model.sv ====
`timescale 1ns/100ps
module fpsb_cbus_model (
  input  wire logic own_busy_i,
  input  wire logic others_busy_i,
  output logic      busy_bus_o
);
  // ----------------------------------------------------------------
  // wired busy of the shared control bus
  // ----------------------------------------------------------------
  // wired-or: this board's own busy shows on the shared line as well
  assign busy_bus_o = own_busy_i | others_busy_i;
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // short counts keep the run brief; a depth of 2 lets the buffer fill
  localparam int CFG = 20;
  localparam int DTK = 4;
  localparam int DEP = 2;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'hF;
  logic [31:0]         wb_dat_i = 32'h0;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                gate_i = 1'b0;
  logic                veto_i = 1'b0;
  logic                fast_clear_input_i = 1'b0;
  logic                ext_reset_i = 1'b0;
  logic                busy_bus;
  logic                others_busy = 1'b0;
  logic                jumper = 1'b0;
  logic                overcurrent_i = 1'b0;
  logic [13:0]         term_sw_i = 14'h0000;
  logic [15:0]         rot_sw_i = 16'h1234;
  logic                busy_o;
  logic                data_ready_o;
  logic                acq_halt_o;
  logic                conv_start_o;
  logic [15:0]         base_addr_o;
  logic [11:0]         thr_counts_o;
  logic [11:0]         max_count_o;
  fpsb_pkg::fpsb_led_t led_o;
  int                  num_errors = 0;
  int                  cmp_count = 0;
  int                  busy_cyc = 0;
  int                  starts = 0;
  logic [13:0]         tv [3] = '{14'h3FFF, 14'h0000, 14'h0101};
  logic [2:0]          te [3] = '{3'b100, 3'b010, 3'b000};

  always #4 clk_i = ~clk_i;
  // mid-cycle sampling keeps the monitors clear of the edge updates
  always @(negedge clk_i)
  begin
    if (busy_o === 1'b1)
      busy_cyc++;
    if (conv_start_o === 1'b1)
      starts++;
  end

  fpsb_cbus_model cbus_u (
    .own_busy_i    (busy_o),
    .others_busy_i (others_busy),
    .busy_bus_o    (busy_bus)
  );

  fpsb_top #(.CFG_CYC(CFG), .DTACK_CYC(DTK), .MEB_DEPTH(DEP)) dut_u (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .wb_cyc_i            (wb_cyc_i),
    .wb_stb_i            (wb_stb_i),
    .wb_we_i             (wb_we_i),
    .wb_adr_i            (wb_adr_i),
    .wb_sel_i            (wb_sel_i),
    .wb_dat_i            (wb_dat_i),
    .wb_dat_o            (wb_dat_o),
    .wb_ack_o            (wb_ack_o),
    .gate_i              (gate_i),
    .veto_i              (veto_i),
    .fast_clear_input_i  (fast_clear_input_i),
    .ext_reset_i         (ext_reset_i),
    .busy_bus_i          (busy_bus),
    .busy_scope_jumper_i (jumper),
    .overcurrent_i       (overcurrent_i),
    .term_sw_i           (term_sw_i),
    .rot_sw_i            (rot_sw_i),
    .busy_o              (busy_o),
    .data_ready_o        (data_ready_o),
    .acq_halt_o          (acq_halt_o),
    .conv_start_o        (conv_start_o),
    .base_addr_o         (base_addr_o),
    .thr_counts_o        (thr_counts_o),
    .max_count_o         (max_count_o),
    .led_o               (led_o)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle: request held until ack is seen, released at that edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    chk("wb_ack", 32'h1, {31'h0, wb_ack_o});
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // pins stay high long enough to pass the two-flop synchronisers
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: gate_i <= 1'b1;
      1: fast_clear_input_i <= 1'b1;
      2: ext_reset_i <= 1'b1;
      default: overcurrent_i <= 1'b1;
    endcase
    repeat (4) @(posedge clk_i);
    gate_i <= 1'b0;
    fast_clear_input_i <= 1'b0;
    ext_reset_i <= 1'b0;
    overcurrent_i <= 1'b0;
  endtask

  task automatic idle(input int m);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (busy_o !== 1'b0 && n < 2000);
    repeat (m) @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("cfg_leds", 32'h7, {led_o.busy, led_o.data_present_indicator, led_o.term_orange});
    repeat (CFG + 10) @(negedge clk_i);
    chk("rot_base", 32'h1234, base_addr_o);
    chk("max_full", 32'hFFF, max_count_o);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      term_sw_i <= tv[i];
      repeat (6) @(negedge clk_i);
      chk("term", te[i], {led_o.term_green, led_o.term_red, led_o.term_orange});
    end
    chk("pwr", 32'h2, {led_o.pwr_green, led_o.pwr_orange});
    wr(fpsb_pkg::ADR_THR, 32'h0F);
    repeat (2) @(negedge clk_i);
    chk("dtack_on", 32'h1, led_o.dtack);
    chk("thr_coarse", 32'h0F0, thr_counts_o);
    repeat (DTK + 6) @(negedge clk_i);
    chk("dtack_off", 32'h0, led_o.dtack);
    wr(fpsb_pkg::ADR_CTRL, 32'h6);
    repeat (2) @(negedge clk_i);
    chk("thr_fine", 32'h01E, thr_counts_o);
    chk("max_slide", 32'hF00, max_count_o);
    wr(fpsb_pkg::ADR_BASE, 32'hABCD);
    wr(fpsb_pkg::ADR_CTRL, 32'h8);
    repeat (2) @(negedge clk_i);
    chk("reg_base", 32'hABCD, base_addr_o);
    rd("unmapped", 8'h20, 32'h0);
    wr(fpsb_pkg::ADR_CTRL, 32'h1);
    repeat (3) @(negedge clk_i);
    chk("mtest_busy", 32'h1, busy_o);
    wr(fpsb_pkg::ADR_CTRL, 32'h0);
    idle(2);
    busy_cyc = 0;
    starts = 0;
    pulse(0);
    // bus busy returns through the model and the pin chain a few cycles late
    repeat (4) @(negedge clk_i);
    rd("st_busy", fpsb_pkg::ADR_STATUS, 32'hC);
    idle(3);
    chk("conv_len", fpsb_pkg::CONV_CYC, busy_cyc);
    chk("starts", 32'h1, starts);
    chk("data_present_indicator", 32'h3, {data_ready_o, led_o.data_present_indicator});
    rd("st_data_present_indicator", fpsb_pkg::ADR_STATUS, 32'h1);
    pulse(0);
    repeat (800) @(negedge clk_i);
    chk("full_busy", 32'h3, {busy_o, led_o.busy});
    rd("ev_two", fpsb_pkg::ADR_EVENT, 32'h2);
    wr(fpsb_pkg::ADR_EVENT, 32'h0);
    idle(2);
    rd("ev_pop", fpsb_pkg::ADR_EVENT, 32'h1);
    @(posedge clk_i);
    veto_i <= 1'b1;
    starts = 0;
    pulse(0);
    repeat (10) @(negedge clk_i);
    chk("veto", 32'h0, starts);
    @(posedge clk_i);
    veto_i <= 1'b0;
    others_busy <= 1'b1;
    jumper <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk("halt_any", 32'h1, acq_halt_o);
    pulse(0);
    repeat (10) @(negedge clk_i);
    chk("halt_gate", 32'h0, starts);
    @(posedge clk_i);
    jumper <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk("halt_own", 32'h0, acq_halt_o);
    @(posedge clk_i);
    others_busy <= 1'b0;
    repeat (5) @(negedge clk_i);
    pulse(0);
    repeat (20) @(negedge clk_i);
    pulse(1);
    pulse(0);
    repeat (10) @(negedge clk_i);
    chk("clr_window", 32'h1, starts);
    idle(3);
    rd("clr_noev", fpsb_pkg::ADR_EVENT, 32'h1);
    wr(fpsb_pkg::ADR_CTRL, 32'h6);
    pulse(2);
    idle(3);
    rd("xr_ctrl", fpsb_pkg::ADR_CTRL, 32'h0);
    rd("xr_event", fpsb_pkg::ADR_EVENT, 32'h0);
    chk("xr_thr", 32'h0, thr_counts_o);
    pulse(3);
    repeat (10) @(negedge clk_i);
    chk("ovc", 32'h1, {led_o.pwr_green, led_o.pwr_orange});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk("ovc_clr", 32'h2, {led_o.pwr_green, led_o.pwr_orange});
    summarize();
  end
endmodule
